/* prescaled_reload_timer_params.svh */
// Constants for the prescaled reload timer
`ifndef PRESCALED_RELOAD_TIMER_PARAMS_SVH
`define PRESCALED_RELOAD_TIMER_PARAMS_SVH

`define CNT_W        8
`define COUNT_RST    8'hff
`define COUNT_ZERO   8'h00
`define COUNT_ONE    8'h01
`define DIV_W        3
`define DIV_ZERO     3'h0
`define DIV_ONE      3'h1
`define DIV8_LAST    3'h7

`endif

/* prescaled_reload_timer_pkg.sv */
// Types shared by the prescaled reload timer modules
`default_nettype none

package prescaled_reload_timer_pkg;

  // Operating mode of the timer
  typedef enum logic [1:0] {
    MODE_TIMER = 2'h0,
    MODE_PULSE = 2'h1,
    MODE_EVENT = 2'h2
  } mode_t;

  // Internal count source select
  typedef enum logic [1:0] {
    SRC_DIV_ONE   = 2'h0,
    SRC_DIV_TWO   = 2'h1,
    SRC_DIV_EIGHT = 2'h2,
    SRC_LOW_OSC   = 2'h3
  } src_t;

  // Write sequence while running, one-hot
  typedef enum logic [2:0] {
    ST_RUN  = 3'h1,
    ST_LOAD = 3'h2,
    ST_XFER = 3'h4
  } wr_state_t;

endpackage

`default_nettype wire

/* tick_if.sv */
// Count source signals between the timer core and its tick generator
`timescale 1ns/10ps
`default_nettype none

interface tick_if;
  prescaled_reload_timer_pkg::mode_t mode;
  prescaled_reload_timer_pkg::src_t  src_sel;
  logic                              polarity;
  logic                              pin_sel;
  logic                              tick;
  logic                              ext_level;

  modport core (output mode, output src_sel, output polarity, output pin_sel,
                input tick, input ext_level);
  modport gen  (input mode, input src_sel, input polarity, input pin_sel,
                output tick, output ext_level);
endinterface

`default_nettype wire

/* tick_source.sv */
// Count source generator: divided clocks, slow oscillator edge or pin edge
`timescale 1ns/10ps
`default_nettype none
`include "prescaled_reload_timer_params.svh"

module tick_source (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic rst_i,
  // Source pins
  input  wire logic low_speed_osc_clock_i,
  input  wire logic count_input_pin_a_i,
  input  wire logic count_input_pin_b_i,
  // Core side
  tick_if.gen       tk
);

  logic [`DIV_W-1:0] div;
  logic [`DIV_W-1:0] next_div;
  logic              osc_prev;
  logic              ext_prev;
  logic              tick;
  logic              ext_level;
  logic              next_tick;
  logic              pin_now;

  // Next values of the divider, edge history and tick
  always_comb begin
    next_div = div + `DIV_ONE;
    pin_now  = tk.pin_sel ? count_input_pin_b_i : count_input_pin_a_i;
    next_tick = 1'b0;
    if (tk.mode == prescaled_reload_timer_pkg::MODE_EVENT) begin
      // Counted edge: rising when polarity low, falling when high
      next_tick = tk.polarity ? (ext_prev & ~pin_now) : (~ext_prev & pin_now);
    end else begin
      case (tk.src_sel)
        prescaled_reload_timer_pkg::SRC_DIV_ONE:   next_tick = 1'b1;
        prescaled_reload_timer_pkg::SRC_DIV_TWO:   next_tick = div[0];
        prescaled_reload_timer_pkg::SRC_DIV_EIGHT: next_tick = (div == `DIV8_LAST);
        prescaled_reload_timer_pkg::SRC_LOW_OSC:   next_tick = low_speed_osc_clock_i & ~osc_prev;
        default:                                   next_tick = 1'b0;
      endcase
    end
  end

  // Registers of the generator
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      div       <= `DIV_ZERO;
      osc_prev  <= 1'b0;
      ext_prev  <= 1'b0;
      tick      <= 1'b0;
      ext_level <= 1'b0;
    end else begin
      div       <= next_div;
      osc_prev  <= low_speed_osc_clock_i;
      ext_prev  <= pin_now;
      tick      <= next_tick;
      ext_level <= pin_now;
    end
  end

  assign tk.tick      = tick;
  assign tk.ext_level = ext_level;

endmodule

`default_nettype wire

/* prescaled_reload_timer.sv */
// Prescaled reload timer core with timer, pulse output and event modes
`timescale 1ns/10ps
`default_nettype none
`include "prescaled_reload_timer_params.svh"

// Overview of operation
// - An 8-bit timer preceded by an 8-bit prescaler, each with a reload register.
// - Both stages count down; timer underflow reloads and counting continues.
// - Counting runs on the selected source: div one, two, eight or slow oscillator.
// - Underflow rate is source rate over (prescale+1) times (timer+1).
// - Run control bit high starts counting in every mode.
// - Run control bit low stops counting; counters hold their values.
// - An interrupt request pulses at every timer underflow.
// - Count outputs show the live counter, never the reload value.
// - A write while stopped loads both reload register and counter.
// - A write while running: reload at tick one, counter at two, count at three.
// - Pulse mode inverts the pin level at every timer underflow.
// - Polarity select sets the starting level of the pulse output.
// - In pulse mode a timer count write returns the pin to its start level.
// - Inverted output enable drives the complement on the second pin.
// - Event mode decrements the prescaler on each active external edge.
// - Polarity select picks rising or falling edges in event mode.
// - Input pin select chooses which pin feeds counting and the interrupt.
module prescaled_reload_timer (
  // Clock and reset
  input  wire logic                  clock_i,
  input  wire logic                  rst_i,
  // Control bits
  input  wire logic                  run_control_bit_i,
  input  wire logic [1:0]            timer_mode_i,
  input  wire logic [1:0]            source_select_i,
  input  wire logic                  polarity_edge_select_i,
  input  wire logic                  inverted_output_enable_i,
  input  wire logic                  input_pin_select_i,
  // Count register writes
  input  wire logic                  timer_count_wr_i,
  input  wire logic [`CNT_W-1:0]     timer_count_wdata_i,
  input  wire logic                  prescaler_count_wr_i,
  input  wire logic [`CNT_W-1:0]     prescaler_count_wdata_i,
  // Clock and pin inputs
  input  wire logic                  low_speed_osc_clock_i,
  input  wire logic                  count_input_pin_a_i,
  input  wire logic                  count_input_pin_b_i,
  // Live counts
  output logic [`CNT_W-1:0]          timer_count_o,
  output logic [`CNT_W-1:0]          prescaler_count_o,
  // Events and pins
  output logic                       timer_irq_o,
  output logic                       external_interrupt_one_o,
  output logic                       timer_io_pin_o,
  output logic                       timer_io_pin_oe_o,
  output logic                       inverted_pin_o,
  output logic                       inverted_pin_oe_o
);

  tick_if tk ();

  prescaled_reload_timer_pkg::mode_t     mode;
  prescaled_reload_timer_pkg::mode_t     next_mode;
  prescaled_reload_timer_pkg::wr_state_t state;
  prescaled_reload_timer_pkg::wr_state_t next_state;

  logic [`CNT_W-1:0] tmr;
  logic [`CNT_W-1:0] pre;
  logic [`CNT_W-1:0] tmr_rld;
  logic [`CNT_W-1:0] pre_rld;
  logic [`CNT_W-1:0] tmr_pend;
  logic [`CNT_W-1:0] pre_pend;
  logic              tmr_flag;
  logic              pre_flag;
  logic [`CNT_W-1:0] next_tmr;
  logic [`CNT_W-1:0] next_pre;
  logic [`CNT_W-1:0] next_tmr_rld;
  logic [`CNT_W-1:0] next_pre_rld;
  logic [`CNT_W-1:0] next_tmr_pend;
  logic [`CNT_W-1:0] next_pre_pend;
  logic              next_tmr_flag;
  logic              next_pre_flag;
  logic              irq;
  logic              pulse;
  logic              pulse_oe;
  logic              inv;
  logic              inv_oe;
  logic              next_irq;
  logic              next_pulse;
  logic              next_pulse_oe;
  logic              next_inv;
  logic              next_inv_oe;
  logic              counting;
  logic              pre_uf;
  logic              tmr_uf;
  logic              any_wr;

  // Step one stage: reload after zero, otherwise decrement
  function automatic logic [`CNT_W-1:0] step_down(input logic [`CNT_W-1:0] cnt,
                                                  input logic [`CNT_W-1:0] rld);
    step_down = (cnt == `COUNT_ZERO) ? rld : cnt - `COUNT_ONE;
  endfunction

  // Configuration handed to the tick generator
  assign tk.mode     = mode;
  assign tk.src_sel  = prescaled_reload_timer_pkg::src_t'(source_select_i);
  assign tk.polarity = polarity_edge_select_i;
  assign tk.pin_sel  = input_pin_select_i;

  tick_source u_tick (
    .clock_i               (clock_i),
    .rst_i                 (rst_i),
    .low_speed_osc_clock_i (low_speed_osc_clock_i),
    .count_input_pin_a_i   (count_input_pin_a_i),
    .count_input_pin_b_i   (count_input_pin_b_i),
    .tk                    (tk)
  );

  // Underflow decode for the current tick
  assign counting = run_control_bit_i && (state == prescaled_reload_timer_pkg::ST_RUN);
  assign pre_uf   = counting && tk.tick && (pre == `COUNT_ZERO);
  assign tmr_uf   = pre_uf && (tmr == `COUNT_ZERO);
  assign any_wr   = timer_count_wr_i || prescaler_count_wr_i;

  // Next values of counters, reloads and the write sequence
  always_comb begin
    next_mode     = mode;
    next_state    = state;
    next_tmr      = tmr;
    next_pre      = pre;
    next_tmr_rld  = tmr_rld;
    next_pre_rld  = pre_rld;
    next_tmr_pend = tmr_pend;
    next_pre_pend = pre_pend;
    next_tmr_flag = tmr_flag;
    next_pre_flag = pre_flag;
    if (!run_control_bit_i) begin
      next_mode = prescaled_reload_timer_pkg::mode_t'(timer_mode_i);
    end
    if (counting && tk.tick) begin
      next_pre = step_down(pre, pre_rld);
      if (pre_uf) begin
        next_tmr = step_down(tmr, tmr_rld);
      end
    end
    case (state)
      prescaled_reload_timer_pkg::ST_RUN: begin
        next_state = prescaled_reload_timer_pkg::ST_RUN;
      end
      prescaled_reload_timer_pkg::ST_LOAD: begin
        if (tk.tick) begin
          // First tick: written values reach the reload registers
          if (tmr_flag) next_tmr_rld = tmr_pend;
          if (pre_flag) next_pre_rld = pre_pend;
          next_state = prescaled_reload_timer_pkg::ST_XFER;
        end
      end
      prescaled_reload_timer_pkg::ST_XFER: begin
        if (tk.tick) begin
          // Second tick: reloads reach the counters, third tick counts
          if (tmr_flag) next_tmr = tmr_rld;
          if (pre_flag) next_pre = pre_rld;
          next_tmr_flag = 1'b0;
          next_pre_flag = 1'b0;
          next_state    = prescaled_reload_timer_pkg::ST_RUN;
        end
      end
      default: begin
        next_state = prescaled_reload_timer_pkg::ST_RUN;
      end
    endcase
    if (!run_control_bit_i) begin
      // Stopped: any unfinished write lands at once in both places
      if (tmr_flag) begin
        next_tmr     = tmr_pend;
        next_tmr_rld = tmr_pend;
      end
      if (pre_flag) begin
        next_pre     = pre_pend;
        next_pre_rld = pre_pend;
      end
      next_tmr_flag = 1'b0;
      next_pre_flag = 1'b0;
      next_state    = prescaled_reload_timer_pkg::ST_RUN;
      if (timer_count_wr_i) begin
        next_tmr     = timer_count_wdata_i;
        next_tmr_rld = timer_count_wdata_i;
      end
      if (prescaler_count_wr_i) begin
        next_pre     = prescaler_count_wdata_i;
        next_pre_rld = prescaler_count_wdata_i;
      end
    end else if (any_wr) begin
      // Running: park the value and restart the write sequence
      if (timer_count_wr_i) begin
        next_tmr_pend = timer_count_wdata_i;
        next_tmr_flag = 1'b1;
      end
      if (prescaler_count_wr_i) begin
        next_pre_pend = prescaler_count_wdata_i;
        next_pre_flag = 1'b1;
      end
      next_state = prescaled_reload_timer_pkg::ST_LOAD;
    end
  end

  // Next values of the event and pin outputs
  always_comb begin
    next_irq   = tmr_uf;
    next_pulse = pulse;
    if (timer_count_wr_i) begin
      next_pulse = polarity_edge_select_i;
    end else if (tmr_uf && mode == prescaled_reload_timer_pkg::MODE_PULSE) begin
      next_pulse = ~pulse;
    end
    next_pulse_oe = (next_mode == prescaled_reload_timer_pkg::MODE_PULSE);
    next_inv      = ~next_pulse;
    next_inv_oe   = next_pulse_oe && inverted_output_enable_i;
  end

  // Registers of the core
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      mode      <= prescaled_reload_timer_pkg::MODE_TIMER;
      state     <= prescaled_reload_timer_pkg::ST_RUN;
      tmr       <= `COUNT_RST;
      pre       <= `COUNT_RST;
      tmr_rld   <= `COUNT_RST;
      pre_rld   <= `COUNT_RST;
      tmr_pend  <= `COUNT_RST;
      pre_pend  <= `COUNT_RST;
      tmr_flag  <= 1'b0;
      pre_flag  <= 1'b0;
      irq       <= 1'b0;
      pulse     <= 1'b0;
      pulse_oe  <= 1'b0;
      inv       <= 1'b1;
      inv_oe    <= 1'b0;
    end else begin
      mode      <= next_mode;
      state     <= next_state;
      tmr       <= next_tmr;
      pre       <= next_pre;
      tmr_rld   <= next_tmr_rld;
      pre_rld   <= next_pre_rld;
      tmr_pend  <= next_tmr_pend;
      pre_pend  <= next_pre_pend;
      tmr_flag  <= next_tmr_flag;
      pre_flag  <= next_pre_flag;
      irq       <= next_irq;
      pulse     <= next_pulse;
      pulse_oe  <= next_pulse_oe;
      inv       <= next_inv;
      inv_oe    <= next_inv_oe;
    end
  end

  // Live counts and pin drivers
  assign timer_count_o            = tmr;
  assign prescaler_count_o        = pre;
  assign timer_irq_o              = irq;
  assign external_interrupt_one_o = tk.ext_level;
  assign timer_io_pin_o           = pulse;
  assign timer_io_pin_oe_o        = pulse_oe;
  assign inverted_pin_o           = inv;
  assign inverted_pin_oe_o        = inv_oe;

  // Checks on the core
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  AST_UF_IRQ: assert property (tmr_uf |=> timer_irq_o)
    else $error("Underflow gave no interrupt");
  AST_NO_IRQ: assert property (!tmr_uf |=> !timer_irq_o)
    else $error("Interrupt without underflow");
  AST_TMR_RELOAD: assert property (tmr_uf && !any_wr |=> timer_count_o == $past(tmr_rld))
    else $error("Timer did not reload at underflow");
  AST_PRE_DEC: assert property (counting && tk.tick && pre != `COUNT_ZERO && !any_wr
                                |=> prescaler_count_o == $past(pre) - `COUNT_ONE)
    else $error("Prescaler did not step down");
  AST_CASCADE: assert property (pre_uf && tmr != `COUNT_ZERO && !any_wr
                                |=> timer_count_o == $past(tmr) - `COUNT_ONE)
    else $error("Timer missed prescaler underflow");
  AST_HOLD: assert property (!run_control_bit_i && !any_wr && !tmr_flag && !pre_flag
                             |=> $stable(timer_count_o) && $stable(prescaler_count_o))
    else $error("Counter moved while stopped");
  AST_STOP_LOAD: assert property (!run_control_bit_i && timer_count_wr_i
                                  |=> tmr == $past(timer_count_wdata_i) && tmr_rld == tmr)
    else $error("Stopped write did not load both");
  AST_RUN_SEQ: assert property (counting && timer_count_wr_i ##1 (run_control_bit_i && !any_wr) [*3]
                                |-> state != prescaled_reload_timer_pkg::ST_RUN || tmr_rld == tmr_pend)
    else $error("Running write sequence broken");
  AST_PULSE_TOGGLE: assert property (tmr_uf && !timer_count_wr_i && mode == prescaled_reload_timer_pkg::MODE_PULSE
                                     |=> timer_io_pin_o != $past(timer_io_pin_o))
    else $error("Pulse did not toggle");
  AST_PULSE_START: assert property (timer_count_wr_i |=> timer_io_pin_o == $past(polarity_edge_select_i))
    else $error("Pulse not at start level after write");
  AST_INV: assert property (inverted_pin_oe_o |-> inverted_pin_o != timer_io_pin_o)
    else $error("Inverted pin not complementary");

  COV_UF: cover property (tmr_uf);
  COV_RUN_WRITE: cover property (counting && timer_count_wr_i ##[1:40] state == prescaled_reload_timer_pkg::ST_RUN);
  COV_PULSE: cover property (pulse_oe && tmr_uf);
  COV_EVENT: cover property (mode == prescaled_reload_timer_pkg::MODE_EVENT && pre_uf);

endmodule

`default_nettype wire

/* timer_pin_partner.sv */
// Model of the parts outside the timer pins: pulse sources, slow oscillator and pin load
`timescale 1ns/10ps
`default_nettype none

module timer_pin_partner (
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic rst_i,
  // Timer pin driven by the block
  input  wire logic timer_io_pin_i,
  input  wire logic timer_io_pin_oe_i,
  // Sources toward the block
  output logic      count_input_pin_a_o,
  output logic      count_input_pin_b_o,
  output logic      low_speed_osc_clock_o
);
  logic       osc_en;
  logic [3:0] osc_div;
  logic [7:0] load_edges;

  // Pins idle low and oscillator off from time zero
  initial begin
    count_input_pin_a_o = 1'b0;
    count_input_pin_b_o = 1'b0;
    osc_en = 1'b0;
  end

  // Slow oscillator, ten clock cycles a period, still while disabled
  always_ff @(posedge clock_i) begin
    if (rst_i || !osc_en) begin
      osc_div <= 4'h0;
      low_speed_osc_clock_o <= 1'b0;
    end else if (osc_div == 4'h4) begin
      osc_div <= 4'h0;
      low_speed_osc_clock_o <= ~low_speed_osc_clock_o;
    end else begin
      osc_div <= osc_div + 4'h1;
    end
  end

  // Load on the pin counts the level changes it is driven through
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      load_edges <= 8'h00;
    end else if (timer_io_pin_oe_i && $changed(timer_io_pin_i)) begin
      load_edges <= load_edges + 8'h01;
    end
  end

  // Drive one external pin to a level just after a clock edge
  task automatic set_pin(input logic sel, input logic lvl);
    @(posedge clock_i);
    if (sel) count_input_pin_b_o <= lvl;
    else count_input_pin_a_o <= lvl;
  endtask

  // Start or stop the slow oscillator
  task automatic osc(input logic en);
    @(posedge clock_i);
    osc_en <= en;
  endtask
endmodule

`default_nettype wire

/* prescaled_reload_timer_bench.sv */
// Self-checking testbench of the prescaled reload timer
`timescale 1ns/10ps
`default_nettype none

module prescaled_reload_timer_bench;
  // Design inputs and outputs
  logic       clock_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       run_control_bit_i = 1'b0;
  logic [1:0] timer_mode_i = 2'h0;
  logic [1:0] source_select_i = 2'h0;
  logic       polarity_edge_select_i = 1'b0;
  logic       inverted_output_enable_i = 1'b0;
  logic       input_pin_select_i = 1'b0;
  logic       timer_count_wr_i = 1'b0;
  logic [7:0] timer_count_wdata_i = 8'h00;
  logic       prescaler_count_wr_i = 1'b0;
  logic [7:0] prescaler_count_wdata_i = 8'h00;
  logic       low_osc, pin_a, pin_b;
  logic [7:0] timer_count_o, prescaler_count_o;
  logic       timer_irq_o, external_interrupt_one_o, timer_io_pin_o, timer_io_pin_oe_o;
  logic       inverted_pin_o, inverted_pin_oe_o;
  int         num_errors = 0;
  int         cmp_count = 0;
  int         g;

  // 200 MHz clock
  always #2.5 clock_i = ~clock_i;

  prescaled_reload_timer i_prescaled_reload_timer (.clock_i(clock_i), .rst_i(rst_i),
    .run_control_bit_i(run_control_bit_i), .timer_mode_i(timer_mode_i), .source_select_i(source_select_i),
    .polarity_edge_select_i(polarity_edge_select_i), .inverted_output_enable_i(inverted_output_enable_i),
    .input_pin_select_i(input_pin_select_i), .timer_count_wr_i(timer_count_wr_i),
    .timer_count_wdata_i(timer_count_wdata_i), .prescaler_count_wr_i(prescaler_count_wr_i),
    .prescaler_count_wdata_i(prescaler_count_wdata_i), .low_speed_osc_clock_i(low_osc),
    .count_input_pin_a_i(pin_a), .count_input_pin_b_i(pin_b), .timer_count_o(timer_count_o),
    .prescaler_count_o(prescaler_count_o), .timer_irq_o(timer_irq_o),
    .external_interrupt_one_o(external_interrupt_one_o), .timer_io_pin_o(timer_io_pin_o),
    .timer_io_pin_oe_o(timer_io_pin_oe_o), .inverted_pin_o(inverted_pin_o),
    .inverted_pin_oe_o(inverted_pin_oe_o));

  timer_pin_partner i_timer_pin_partner (.clock_i(clock_i), .rst_i(rst_i), .timer_io_pin_i(timer_io_pin_o),
    .timer_io_pin_oe_i(timer_io_pin_oe_o), .count_input_pin_a_o(pin_a), .count_input_pin_b_o(pin_b),
    .low_speed_osc_clock_o(low_osc));

  // Compare tasks, one per kind of result
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (s !== e) begin num_errors++; $display("[FAIL] %s expected %h seen %h", n, e, s); end
  endtask
  task automatic chk_bit(input string n, input logic e, input logic s);
    cmp_count++;
    if (s !== e) begin num_errors++; $display("[FAIL] %s expected %b seen %b", n, e, s); end
  endtask
  task automatic chk_int(input string n, input int e, input int s);
    cmp_count++;
    if (s != e) begin num_errors++; $display("[FAIL] %s expected %0d seen %0d", n, e, s); end
  endtask

  // Stop counting and set mode, source and pin options
  task automatic ctrl(input logic [1:0] m, input logic [1:0] s, input logic pol, input logic inv, input logic ps);
    @(posedge clock_i);
    run_control_bit_i <= 1'b0;
    @(posedge clock_i);
    timer_mode_i <= m;
    source_select_i <= s;
    polarity_edge_select_i <= pol;
    inverted_output_enable_i <= inv;
    input_pin_select_i <= ps;
  endtask
  task automatic run(input logic v);
    @(posedge clock_i);
    run_control_bit_i <= v;
    @(negedge clock_i);
  endtask
  // One-cycle write of either or both count registers
  task automatic wr(input logic wp, input logic [7:0] p, input logic wt, input logic [7:0] t);
    @(posedge clock_i);
    prescaler_count_wr_i <= wp;
    prescaler_count_wdata_i <= p;
    timer_count_wr_i <= wt;
    timer_count_wdata_i <= t;
    @(posedge clock_i);
    prescaler_count_wr_i <= 1'b0;
    timer_count_wr_i <= 1'b0;
    @(negedge clock_i);
  endtask
  // Cycles between two interrupt pulses
  task automatic irq_gap(output int n);
    int k;
    k = 0;
    while (timer_irq_o !== 1'b1 && k < 400) begin @(negedge clock_i); k++; end
    @(negedge clock_i);
    n = 1;
    while (timer_irq_o !== 1'b1 && n < 400) begin @(negedge clock_i); n++; end
  endtask
  // Cycles between two level changes of the pulse pin
  task automatic pin_gap(output int n);
    logic l;
    l = timer_io_pin_o;
    n = 0;
    while (timer_io_pin_o === l && n < 400) begin @(negedge clock_i); n++; end
    l = timer_io_pin_o;
    n = 0;
    while (timer_io_pin_o === l && n < 400) begin @(negedge clock_i); n++; end
  endtask

  // Reset state of counts and pins
  task automatic t_reset;
    chk8("timer after reset", 8'hff, timer_count_o);
    chk8("prescaler after reset", 8'hff, prescaler_count_o);
    chk_bit("pin oe after reset", 1'b0, timer_io_pin_oe_o);
    chk_bit("inv oe after reset", 1'b0, inverted_pin_oe_o);
    $display("test reset done");
  endtask

  // Underflow period on all four sources, prescale 2 and timer 3
  task automatic t_sources;
    int mult[4] = '{1, 2, 8, 10};
    i_timer_pin_partner.osc(1'b1);
    for (int s = 0; s < 4; s++) begin
      ctrl(prescaled_reload_timer_pkg::MODE_TIMER, s[1:0], 1'b0, 1'b0, 1'b0);
      wr(1'b1, 8'h02, 1'b1, 8'h03);
      chk8("prescaler stopped write", 8'h02, prescaler_count_o);
      chk8("timer stopped write", 8'h03, timer_count_o);
      run(1'b1);
      irq_gap(g);
      chk_int("irq period", 12 * mult[s], g);
      irq_gap(g);
      chk_int("irq period again", 12 * mult[s], g);
    end
    i_timer_pin_partner.osc(1'b0);
    $display("test sources done");
  endtask

  // Stop holds live counts
  task automatic t_hold;
    logic [7:0] p, t;
    ctrl(prescaled_reload_timer_pkg::MODE_TIMER, 2'h0, 1'b0, 1'b0, 1'b0);
    wr(1'b1, 8'h20, 1'b1, 8'h20);
    run(1'b1);
    repeat (7) @(negedge clock_i);
    run(1'b0);
    repeat (2) @(negedge clock_i);
    p = prescaler_count_o;
    t = timer_count_o;
    chk_bit("prescaler live", 1'b1, p < 8'h20);
    repeat (10) @(negedge clock_i);
    chk8("prescaler held", p, prescaler_count_o);
    chk8("timer held", t, timer_count_o);
    $display("test hold done");
  endtask

  // Write while running on the divide-by-eight source
  task automatic t_running_write;
    int k;
    ctrl(prescaled_reload_timer_pkg::MODE_TIMER, 2'h2, 1'b0, 1'b0, 1'b0);
    wr(1'b1, 8'h00, 1'b1, 8'h10);
    run(1'b1);
    repeat (20) @(negedge clock_i);
    wr(1'b0, 8'h00, 1'b1, 8'h40);
    k = 0;
    while (timer_count_o !== 8'h40 && k < 40) begin @(negedge clock_i); k++; end
    chk_bit("transfer by second tick", 1'b1, k <= 17);
    k = 0;
    while (timer_count_o === 8'h40 && k < 40) begin @(negedge clock_i); k++; end
    chk_int("resume one tick later", 8, k);
    chk8("first step after resume", 8'h3f, timer_count_o);
    $display("test running write done");
  endtask

  // Pulse output, start level, inverted pin and write restart
  task automatic t_pulse;
    logic [7:0] e0;
    ctrl(prescaled_reload_timer_pkg::MODE_PULSE, 2'h0, 1'b1, 1'b1, 1'b0);
    wr(1'b1, 8'h01, 1'b1, 8'h02);
    chk_bit("pin start high", 1'b1, timer_io_pin_o);
    chk_bit("pin oe", 1'b1, timer_io_pin_oe_o);
    chk_bit("inv oe", 1'b1, inverted_pin_oe_o);
    run(1'b1);
    e0 = i_timer_pin_partner.load_edges;
    pin_gap(g);
    chk_int("half period", 6, g);
    @(negedge clock_i);
    chk_int("load saw two changes", 2, int'(i_timer_pin_partner.load_edges - e0));
    chk_bit("inverse pin", ~timer_io_pin_o, inverted_pin_o);
    g = 0;
    while (timer_io_pin_o !== 1'b0 && g < 20) begin @(negedge clock_i); g++; end
    run(1'b0);
    chk_bit("pin low before write", 1'b0, timer_io_pin_o);
    wr(1'b0, 8'h00, 1'b1, 8'h02);
    chk_bit("pin back to start", 1'b1, timer_io_pin_o);
    ctrl(prescaled_reload_timer_pkg::MODE_PULSE, 2'h0, 1'b0, 1'b0, 1'b0);
    wr(1'b0, 8'h00, 1'b1, 8'h02);
    chk_bit("pin start low", 1'b0, timer_io_pin_o);
    chk_bit("inv oe off", 1'b0, inverted_pin_oe_o);
    $display("test pulse done");
  endtask

  // Event counting on pin b, rising then falling edges
  task automatic t_event;
    ctrl(prescaled_reload_timer_pkg::MODE_EVENT, 2'h0, 1'b0, 1'b0, 1'b1);
    wr(1'b1, 8'h03, 1'b1, 8'h05);
    run(1'b1);
    // Mode change while running must be ignored
    @(posedge clock_i);
    timer_mode_i <= 2'h1;
    i_timer_pin_partner.set_pin(1'b1, 1'b1);
    repeat (4) @(negedge clock_i);
    chk8("rising edge counted", 8'h02, prescaler_count_o);
    chk_bit("ext int follows pin b", 1'b1, external_interrupt_one_o);
    chk_bit("mode held while running", 1'b0, timer_io_pin_oe_o);
    i_timer_pin_partner.set_pin(1'b1, 1'b0);
    i_timer_pin_partner.set_pin(1'b0, 1'b1);
    i_timer_pin_partner.set_pin(1'b0, 1'b0);
    repeat (4) @(negedge clock_i);
    chk8("falling and pin a ignored", 8'h02, prescaler_count_o);
    chk_bit("ext int low", 1'b0, external_interrupt_one_o);
    ctrl(prescaled_reload_timer_pkg::MODE_EVENT, 2'h0, 1'b1, 1'b0, 1'b1);
    wr(1'b1, 8'h03, 1'b0, 8'h00);
    run(1'b1);
    i_timer_pin_partner.set_pin(1'b1, 1'b1);
    repeat (4) @(negedge clock_i);
    chk8("rising ignored", 8'h03, prescaler_count_o);
    i_timer_pin_partner.set_pin(1'b1, 1'b0);
    repeat (4) @(negedge clock_i);
    chk8("falling counted", 8'h02, prescaler_count_o);
    $display("test event done");
  endtask

  // Print counts and verdict, then end the run
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge clock_i);
    rst_i <= 1'b0;
    @(negedge clock_i);
    t_reset();
    t_sources();
    t_hold();
    t_running_write();
    t_pulse();
    t_event();
    close_out();
  end

  // Watchdog well beyond the expected run of about a thousand cycles
  initial begin
    #200000;
    num_errors++;
    $display("watchdog expired");
    close_out();
  end
endmodule

`default_nettype wire
